// file: shared/sbc_pkg.sv
// Constants and types shared by the reset, watchdog and wake-up logic
package sbc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ       = 100;
  localparam int RST_DUR_US    = 3400;  // Reset low time
  localparam int NREQ_MS       = 350;   // Normal request window
  localparam int WD_PERIOD_MS  = 10;    // Shortest watchdog period
  localparam int INT_PULSE_US  = 10;
  localparam int CYC_PERIOD_MS = 50;    // Cyclic sense period
  localparam int CYC_ON_US     = 200;   // Switch on time per period
  localparam int RST_DUR_CYC   = RST_DUR_US * CLK_MHZ;
  localparam int NREQ_CYC      = NREQ_MS * 1000 * CLK_MHZ;
  localparam int WD_PERIOD_CYC = WD_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
  localparam int CYC_PER_CYC   = CYC_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int CYC_ON_CYC    = CYC_ON_US * CLK_MHZ;

  // ****************************************
  // Field values and reset values
  // ****************************************
  localparam logic       SAFE_RST   = 1'b0;  // Output mode 1
  localparam logic [1:0] SENSE_OFF  = 2'h0;
  localparam logic [1:0] SENSE_HIGH = 2'h1;
  localparam logic [1:0] SENSE_LOW  = 2'h2;
  localparam logic [1:0] SENSE_ANY  = 2'h3;
  localparam logic [3:0] SENSE_RST  = 4'h0;
  localparam int         PAIR0_LSB  = 0;
  localparam int         PAIR1_LSB  = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    cmd_keep, cmd_normal, cmd_standby, cmd_sleep, cmd_stop,
    cmd_dbg_normal, cmd_dbg_standby, cmd_dbg_stop
  } mode_cmd_t;

  typedef enum logic [2:0] {
    st_reset, st_norm_req, st_normal, st_standby, st_stop, st_sleep
  } sbc_state_t;

  typedef struct packed {
    logic      safe;
    mode_cmd_t cmd;
  } mode_ctrl_t;

  typedef struct packed {
    logic input_bias_from_switch;
    logic switch_auto_cycle;
    logic forced_wake;
  } low_power_ctrl_t;

  typedef struct packed {
    logic window;
    logic run_in_stop;
  } wd_timing_t;

  typedef struct packed {
    logic       can;
    logic [3:0] lines;
  } wake_src_t;

  localparam low_power_ctrl_t LPC_RST = '0;
  localparam wd_timing_t      WDT_RST = '{window: 1'b1, run_in_stop: 1'b0};

endpackage

// file: tb/host_model.sv
// Host side model driving the control write strobes
`timescale 1ns/10ps
`default_nettype none
module host_model
  import sbc_pkg::*;
(
  input  wire logic       ref_clk,
  output logic            mode_ctrl_wr,
  output mode_ctrl_t      mode_ctrl_data,
  output logic            low_power_wr,
  output low_power_ctrl_t low_power_data,
  output logic            wake_sense_wr,
  output logic [3:0]      wake_sense_data,
  output logic            watchdog_timing_wr,
  output wd_timing_t      watchdog_timing_data,
  output logic            wake_status_rd
);
  // Idle strobes at time zero
  initial begin
    {mode_ctrl_wr, low_power_wr, wake_sense_wr} = 3'h0;
    {watchdog_timing_wr, wake_status_rd} = 2'h0;
    {mode_ctrl_data, low_power_data, wake_sense_data, watchdog_timing_data} = '0;
  end
  // One write: 0 mode, 1 low power, 2 sense, 3 watchdog, 4 status read
  task automatic wr(input int k, input logic [3:0] d);
    @(negedge ref_clk);
    mode_ctrl_data = mode_ctrl_t'(d);
    low_power_data = low_power_ctrl_t'(d[2:0]);
    wake_sense_data = d;
    watchdog_timing_data = wd_timing_t'(d[1:0]);
    mode_ctrl_wr = (k == 0);
    low_power_wr = (k == 1);
    wake_sense_wr = (k == 2);
    watchdog_timing_wr = (k == 3);
    wake_status_rd = (k == 4);
    @(negedge ref_clk);
    {mode_ctrl_wr, low_power_wr, wake_sense_wr} = 3'h0;
    {watchdog_timing_wr, wake_status_rd} = 2'h0;
    // Stale mode and sense data is inverted so nothing leans on a held value
    mode_ctrl_data = ~mode_ctrl_data;
    wake_sense_data = ~wake_sense_data;
  endtask
endmodule // host_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the reset, watchdog and wake-up block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sbc_pkg::*;
  localparam int RD = 20;
  localparam int WD = 400;
  logic ref_clk, rst, vdd_ok, rst_n, fault_n, int_n, main_on, trk, hs;
  logic fwe, safe_mode, debug_mode;
  logic can_wake, hs_req;
  logic m_wr, l_wr, s_wr, w_wr, s_rd;
  logic [3:0] wake_inputs, lvl, s_d;
  logic [7:0] seed;
  mode_ctrl_t m_d;
  low_power_ctrl_t l_d;
  wd_timing_t w_d;
  wake_src_t wst;
  sbc_state_t st;
  int n_fail, num_checks;

  host_model i_host (.ref_clk(ref_clk), .mode_ctrl_wr(m_wr), .mode_ctrl_data(m_d),
    .low_power_wr(l_wr), .low_power_data(l_d), .wake_sense_wr(s_wr),
    .wake_sense_data(s_d), .watchdog_timing_wr(w_wr), .watchdog_timing_data(w_d),
    .wake_status_rd(s_rd));

  sbc_reset_watchdog_wakeup #(.RST_DUR(RD), .NREQ_DUR(200), .WD_DUR(WD),
    .CYC_PER(30), .CYC_ON(5)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .mode_ctrl_wr(m_wr),
    .mode_ctrl_data(m_d), .low_power_wr(l_wr), .low_power_data(l_d),
    .wake_sense_wr(s_wr), .wake_sense_data(s_d), .watchdog_timing_wr(w_wr),
    .watchdog_timing_data(w_d), .wake_status_rd(s_rd), .hs_switch_req(hs_req),
    .vdd_ok_pin(vdd_ok), .wake_inputs(wake_inputs), .can_wake_pin(can_wake),
    .cs_pin(1'b0), .rst_n(rst_n), .watchdog_fault_out_n(fault_n), .int_n(int_n),
    .main_reg_on(main_on), .tracking_regulator(trk), .battery_high_side_switch(hs),
    .wakeup_status_reg(wst), .wake_input_level(lvl), .forced_wake_en(fwe),
    .safe_mode(safe_mode), .debug_mode(debug_mode), .sbc_state(st));

  // Free running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Expected live level after sync: the pin level itself
  function automatic logic [3:0] exp_lvl(input logic [3:0] w);
    return w;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_st(input sbc_state_t s, input int lim);
    for (int i = 0; i < lim && st !== s; i++) @(negedge ref_clk);
  endtask
  // Bounded wait for the fault output to drop
  task automatic wait_fault(input int lim);
    for (int i = 0; i < lim && fault_n !== 1'b0; i++) @(negedge ref_clk);
  endtask
  // Service in timeout mode, then command normal within the request window
  task automatic go_normal(input logic safe);
    wait_st(st_norm_req, 4 * RD);
    i_host.wr(3, 4'h0);
    i_host.wr(0, {safe, cmd_normal});
    chk(st, st_normal);
  endtask

  // Watchdog over the whole run
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  // Main sequence, inputs move on falling edges
  initial begin
    rst = 1'b1;
    vdd_ok = 1'b1;
    wake_inputs = 4'h0;
    can_wake = 1'b0;
    hs_req = 1'b1;
    seed = 8'h09;
    cyc(8);
    rst = 1'b0;
    chk(safe_mode, SAFE_RST);
    cyc(10);
    chk({rst_n, fault_n}, 2'h1);
    wait_st(st_norm_req, RD + 5);
    chk(rst_n, 1'b1);
    chk({trk, hs, main_on}, 3'h1);
    go_normal(1'b0);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wake_inputs = seed[3:0];
      hs_req = seed[4];
      cyc(4);
      chk(lvl, exp_lvl(seed[3:0]));
      chk(hs, seed[4]);
    end
    wake_inputs = 4'h0;
    // Request held high so later request modes must override it
    hs_req = 1'b1;
    // Mode 1 timeout, then proper service
    wait_fault(WD + 20);
    chk({fault_n, rst_n}, 2'h0);
    wait_st(st_norm_req, 4 * RD);
    chk(fault_n, 1'b0);
    go_normal(1'b0);
    chk(fault_n, 1'b1);
    // Safe mode timeout keeps reset high
    i_host.wr(0, {1'b1, cmd_keep});
    chk(safe_mode, 1'b1);
    wait_fault(WD + 20);
    chk({fault_n, rst_n, st}, {2'h1, st_normal});
    i_host.wr(3, 4'h0);
    chk(fault_n, 1'b1);
    i_host.wr(0, {1'b0, cmd_keep});
    // Closed window service
    i_host.wr(3, 4'h2);
    i_host.wr(3, 4'h2);
    wait_fault(5);
    chk({fault_n, rst_n}, 2'h0);
    go_normal(1'b0);
    // Direct wake from stop, only pair 0 sensitive
    i_host.wr(2, {SENSE_OFF, SENSE_HIGH});
    i_host.wr(1, 4'h0);
    i_host.wr(0, {1'b0, cmd_stop});
    wake_inputs = 4'h8;
    cyc(10);
    chk({st, rst_n}, {st_stop, 1'b1});
    wake_inputs = 4'h9;
    can_wake = 1'b1;
    for (int i = 0; i < 10 && int_n !== 1'b0; i++) @(negedge ref_clk);
    chk({int_n, st}, {1'b0, st_norm_req});
    chk(wst, 5'h11);
    i_host.wr(4, 4'h0);
    chk(wst, 5'h00);
    wake_inputs = 4'h0;
    can_wake = 1'b0;
    go_normal(1'b0);
    // Cyclic sense from sleep, forced wake refused
    i_host.wr(2, 4'hf);
    i_host.wr(1, 4'h7);
    chk(fwe, 1'b0);
    i_host.wr(0, {1'b0, cmd_sleep});
    cyc(2);
    chk({st, rst_n, int_n, main_on}, {st_sleep, 3'h2});
    for (int i = 0; i < 50 && hs !== 1'b1; i++) @(negedge ref_clk);
    chk(hs, 1'b1);
    wake_inputs = 4'h4;
    for (int i = 0; i < 80 && st === st_sleep; i++) @(negedge ref_clk);
    chk({st, main_on}, {st_reset, 1'b1});
    chk(wst.lines, 4'h4);
    go_normal(1'b0);
    // Debug normal: watchdog halted, undervoltage still resets
    i_host.wr(0, {1'b0, cmd_dbg_normal});
    chk(debug_mode, 1'b1);
    cyc(WD + 20);
    chk({fault_n, rst_n}, 2'h3);
    vdd_ok = 1'b0;
    cyc(4);
    chk(rst_n, 1'b0);
    print_verdict();
  end
endmodule // tb
`default_nettype wire

// file: verilog/sbc_reset_watchdog_wakeup.sv
// Reset, watchdog output modes and wake-up logic of the system basis chip
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Safe bit picks output mode 1 or 2, regardless of operating mode.
// - Output mode 1 after rst; undervoltage and wake-up resets keep the safe bit.
// - Reset asserted at power-up and on sleep wake-up in both modes.
// - Mode 1: reset on regulator undervoltage or unserviced watchdog.
// - Fault output low with watchdog reset, held until proper service.
// - Mode 2: no reset on watchdog fault, fault output driven low.
// - Stop keeps reset high except mode 1 watchdog expiry or undervoltage.
// - Wake-up source recorded in status register for host reading, except a chip select wake.
// - Sleep wake-up turns main regulator on; stop wake-up interrupts host.
// - Live state of four wake inputs readable by host.
// - Inputs 0,1 share one sensitivity; inputs 2,3 share another.
// - Cyclic sense pulses the battery switch from a timer when low power.
// - Cyclic sense wakes on change of any sampled wake input whose pair sensitivity is not off.
// - Forced wake-up cannot be enabled while cyclic sense is on.
// - Wake method applies to all four inputs alike.
// - Reset mode holds reset low for its timer, then normal request.
// - Window watchdog service in closed part causes reset in mode 1.
module sbc_reset_watchdog_wakeup
  import sbc_pkg::*;
#(
  parameter int unsigned RST_DUR  = RST_DUR_CYC,
  parameter int unsigned NREQ_DUR = NREQ_CYC,
  parameter int unsigned WD_DUR   = WD_PERIOD_CYC,
  parameter int unsigned CYC_PER  = CYC_PER_CYC,
  parameter int unsigned CYC_ON   = CYC_ON_CYC
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            clk_en,
  input  wire logic            mode_ctrl_wr,
  input  wire mode_ctrl_t      mode_ctrl_data,
  input  wire logic            low_power_wr,
  input  wire low_power_ctrl_t low_power_data,
  input  wire logic            wake_sense_wr,
  input  wire logic [3:0]      wake_sense_data,
  input  wire logic            watchdog_timing_wr,
  input  wire wd_timing_t      watchdog_timing_data,
  input  wire logic            wake_status_rd,
  input  wire logic            hs_switch_req,
  input  wire logic            vdd_ok_pin,
  input  wire logic [3:0]      wake_inputs,
  input  wire logic            can_wake_pin,
  input  wire logic            cs_pin,
  output logic                 rst_n,
  output logic                 watchdog_fault_out_n,
  output logic                 int_n,
  output logic                 main_reg_on,
  output logic                 tracking_regulator,
  output logic                 battery_high_side_switch,
  output wake_src_t            wakeup_status_reg,
  output logic [3:0]           wake_input_level,
  output logic                 forced_wake_en,
  output logic                 safe_mode,
  output logic                 debug_mode,
  output sbc_state_t           sbc_state
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (RST_DUR < 2 || NREQ_DUR < 2 || WD_DUR < 4 || CYC_ON < 1 || CYC_ON >= CYC_PER)
  begin : g_bad_param
    $error("sbc_reset_watchdog_wakeup: timing parameters out of range");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic       cs_prev;
  logic [3:0] lines_s;
  logic       vdd_low;
  logic       can_s;
  logic       cs_rise;

  // Only the second stage feeds logic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1   <= 7'h00;
      sync2   <= 7'h00;
      cs_prev <= 1'b0;
    end else if (clk_en) begin
      sync1   <= {cs_pin, can_wake_pin, vdd_ok_pin, wake_inputs};
      sync2   <= sync1;
      cs_prev <= sync2[6];
    end
  end

  assign lines_s = sync2[3:0];
  assign vdd_low = !sync2[4];
  assign can_s   = sync2[5];
  assign cs_rise = sync2[6] && !cs_prev;

  // ****************************************
  // Operating mode and watchdog
  // ****************************************
  sbc_state_t      state_q, next_state;
  logic [31:0]     tmr_q, next_tmr;
  logic [31:0]     wd_cnt, next_wd_cnt;
  logic [31:0]     int_cnt, next_int_cnt;
  logic            wd_cfg, next_wd_cfg;
  logic            from_sleep, next_from_sleep;
  logic            next_safe, next_debug, next_fault_n;
  low_power_ctrl_t low_power_control_reg, next_lpc;
  wd_timing_t      watchdog_timing_reg, next_wdt;
  logic [3:0]      sense, next_sense;
  logic            cfg_ok, cyclic, wd_run, wd_closed, svc;
  logic            wd_good, wd_bad, wake_ev;

  assign cfg_ok = state_q inside {st_norm_req, st_normal, st_standby};
  assign cyclic = low_power_control_reg.input_bias_from_switch &&
                  low_power_control_reg.switch_auto_cycle;
  // Watchdog idle in debug, sleep and the start-up modes
  assign wd_run = !debug_mode && (state_q inside {st_normal, st_standby} ||
                  (state_q == st_stop && watchdog_timing_reg.run_in_stop));
  assign wd_closed = watchdog_timing_reg.window && wd_cnt < 32'(WD_DUR / 2);
  assign svc       = watchdog_timing_wr && cfg_ok;
  assign wd_good   = svc && !(wd_run && wd_closed);
  assign wd_bad    = wd_run && ((svc && wd_closed) ||
                     (!svc && wd_cnt == 32'(WD_DUR - 1)));

  always_comb begin
    next_state      = state_q;
    next_tmr        = tmr_q + 32'h1;
    next_wd_cfg     = wd_cfg;
    next_from_sleep = from_sleep;
    next_safe       = safe_mode;
    next_debug      = debug_mode;
    next_lpc        = low_power_control_reg;
    next_wdt        = watchdog_timing_reg;
    next_sense      = sense;
    // Safe bit honoured in every operating mode
    if (mode_ctrl_wr) begin
      next_safe = mode_ctrl_data.safe;
    end
    // Wake options only taken while the host is awake
    if (low_power_wr && cfg_ok) begin
      next_lpc = low_power_data;
      next_lpc.forced_wake = low_power_data.forced_wake &&
        !(low_power_data.input_bias_from_switch &&
          low_power_data.switch_auto_cycle);
    end
    if (wake_sense_wr && cfg_ok) begin
      next_sense = wake_sense_data;
    end
    if (svc) begin
      next_wdt = watchdog_timing_data;
    end
    case (state_q)
      st_reset: begin
        if (vdd_low) begin
          next_tmr = 32'h0;
        end else if (tmr_q >= 32'(RST_DUR - 1)) begin
          next_state = st_norm_req;
        end
      end
      st_norm_req: begin
        if (svc) begin
          next_wd_cfg = 1'b1;
        end
        if (vdd_low) begin
          next_state = st_reset;
        end else if (mode_ctrl_wr && wd_cfg &&
                     mode_ctrl_data.cmd inside {cmd_normal, cmd_standby,
                                                cmd_dbg_normal, cmd_dbg_standby}) begin
          next_state = mode_ctrl_data.cmd inside {cmd_normal, cmd_dbg_normal} ?
                       st_normal : st_standby;
          next_debug = mode_ctrl_data.cmd inside {cmd_dbg_normal, cmd_dbg_standby};
          next_from_sleep = 1'b0;
        end else if (tmr_q >= 32'(NREQ_DUR - 1)) begin
          next_state = from_sleep ? st_sleep : st_reset;
        end
      end
      st_normal, st_standby: begin
        if (vdd_low || (wd_bad && !safe_mode)) begin
          next_state = st_reset;
        end else if (mode_ctrl_wr) begin
          case (mode_ctrl_data.cmd)
            cmd_normal, cmd_dbg_normal:   next_state = st_normal;
            cmd_standby, cmd_dbg_standby: next_state = st_standby;
            cmd_sleep:                    next_state = st_sleep;
            cmd_stop, cmd_dbg_stop:       next_state = st_stop;
            default:                      next_state = state_q;
          endcase
          if (mode_ctrl_data.cmd != cmd_keep) begin
            next_debug = mode_ctrl_data.cmd inside {cmd_dbg_normal, cmd_dbg_standby,
                                                    cmd_dbg_stop};
          end
        end
      end
      st_stop: begin
        if (vdd_low || (wd_bad && !safe_mode)) begin
          next_state = st_reset;
        end else if (wake_ev) begin
          next_state = st_norm_req;
        end
      end
      st_sleep: begin
        if (wake_ev) begin
          next_state      = st_reset;
          next_from_sleep = 1'b1;
        end
      end
      default: next_state = st_reset;
    endcase
    if (next_state != state_q) begin
      next_tmr = 32'h0;
    end
    if (next_state == st_norm_req && state_q != st_norm_req) begin
      next_wd_cfg = 1'b0;
    end
    next_wd_cnt = (!wd_run || svc || wd_bad) ? 32'h0 : wd_cnt + 32'h1;
    // Fault output falls with the watchdog reset, rises on service
    next_fault_n = wd_bad ? 1'b0 : (wd_good ? 1'b1 : watchdog_fault_out_n);
    if (state_q == st_stop && next_state == st_norm_req) begin
      next_int_cnt = 32'(INT_PULSE_CYC);
    end else if (next_state == st_sleep) begin
      // A pulse left over from a stop wake must not reach into sleep
      next_int_cnt = 32'h0;
    end else begin
      next_int_cnt = (int_cnt != 32'h0) ? int_cnt - 32'h1 : 32'h0;
    end
  end

  // Outputs follow the next mode so they change with it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q               <= st_reset;
      tmr_q                 <= 32'h0;
      wd_cnt                <= 32'h0;
      int_cnt               <= 32'h0;
      wd_cfg                <= 1'b0;
      from_sleep            <= 1'b0;
      safe_mode             <= SAFE_RST;
      debug_mode            <= 1'b0;
      low_power_control_reg <= LPC_RST;
      watchdog_timing_reg   <= WDT_RST;
      sense                 <= SENSE_RST;
      watchdog_fault_out_n  <= 1'b1;
      rst_n                 <= 1'b0;
      int_n                 <= 1'b1;
      main_reg_on           <= 1'b1;
      tracking_regulator    <= 1'b0;
      forced_wake_en        <= 1'b0;
      sbc_state             <= st_reset;
    end else if (clk_en) begin
      state_q               <= next_state;
      tmr_q                 <= next_tmr;
      wd_cnt                <= next_wd_cnt;
      int_cnt               <= next_int_cnt;
      wd_cfg                <= next_wd_cfg;
      from_sleep            <= next_from_sleep;
      safe_mode             <= next_safe;
      debug_mode            <= next_debug;
      low_power_control_reg <= next_lpc;
      watchdog_timing_reg   <= next_wdt;
      sense                 <= next_sense;
      watchdog_fault_out_n  <= next_fault_n;
      rst_n                 <= !(next_state inside {st_reset, st_sleep});
      int_n                 <= next_int_cnt == 32'h0;
      main_reg_on           <= next_state != st_sleep;
      tracking_regulator    <= next_state == st_normal;
      forced_wake_en        <= next_lpc.forced_wake;
      sbc_state             <= next_state;
    end
  end

  // ****************************************
  // Wake detection and cyclic sense
  // ****************************************
  logic [31:0] cyc_cnt, next_cyc_cnt;
  logic [3:0]  ref_lvl, next_ref;
  logic [3:0]  line_hit;
  logic        low_q, sample_pt, next_hs;
  wake_src_t   next_status;

  assign sample_pt = cyclic && cyc_cnt == 32'(CYC_ON - 1);

  // One method for all inputs; sensitivity shared per pair
  always_comb begin
    logic [1:0] code;
    code = SENSE_OFF;
    for (int i = 0; i < 4; i++) begin
      code = (i < 2) ? sense[PAIR0_LSB +: 2] : sense[PAIR1_LSB +: 2];
      if (cyclic) begin
        line_hit[i] = sample_pt && code != SENSE_OFF && lines_s[i] != ref_lvl[i];
      end else begin
        case (code)
          SENSE_HIGH: line_hit[i] = lines_s[i];
          SENSE_LOW:  line_hit[i] = !lines_s[i];
          SENSE_ANY:  line_hit[i] = lines_s[i] != ref_lvl[i];
          default:    line_hit[i] = 1'b0;
        endcase
      end
    end
  end

  assign wake_ev = low_q && (|line_hit || can_s || cs_rise);

  always_comb begin
    next_ref     = ref_lvl;
    next_cyc_cnt = 32'h0;
    // Reference level taken on entry and at each cyclic sample
    if (!low_q || sample_pt) begin
      next_ref = lines_s;
    end
    if (next_state inside {st_stop, st_sleep} && cyclic) begin
      next_cyc_cnt = (cyc_cnt >= 32'(CYC_PER - 1)) ? 32'h0 : cyc_cnt + 32'h1;
    end
    // Read clears, but a new source in the same cycle survives
    next_status = wake_status_rd ? wake_src_t'(5'h00) : wakeup_status_reg;
    if (wake_ev) begin
      next_status.lines = next_status.lines | line_hit;
      next_status.can   = next_status.can | can_s;
    end
    case (next_state)
      st_normal, st_standby: next_hs = hs_switch_req;
      st_stop, st_sleep:     next_hs = cyclic && next_cyc_cnt < 32'(CYC_ON);
      default:               next_hs = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cyc_cnt                  <= 32'h0;
      ref_lvl                  <= 4'h0;
      low_q                    <= 1'b0;
      wakeup_status_reg        <= '0;
      wake_input_level         <= 4'h0;
      battery_high_side_switch <= 1'b0;
    end else if (clk_en) begin
      cyc_cnt                  <= next_cyc_cnt;
      ref_lvl                  <= next_ref;
      low_q                    <= next_state inside {st_stop, st_sleep};
      wakeup_status_reg        <= next_status;
      wake_input_level         <= lines_s;
      battery_high_side_switch <= next_hs;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  safe_default_a: assert property ($past(rst) |-> !safe_mode)
    else $error("output mode not 1 after reset");
  mode1_wd_rst_a: assert property (clk_en && !safe_mode && wd_bad |=>
    state_q == st_reset && !rst_n && !watchdog_fault_out_n)
    else $error("mode 1 watchdog fault without reset");
  safe_no_rst_a: assert property (clk_en && safe_mode && wd_bad && !vdd_low &&
    !mode_ctrl_wr && state_q != st_stop |=> rst_n && !watchdog_fault_out_n)
    else $error("mode 2 watchdog fault handled wrongly");
  fault_hold_a: assert property (!watchdog_fault_out_n && !(clk_en && wd_good)
    |=> !watchdog_fault_out_n)
    else $error("fault output released without service");
  closed_win_a: assert property (clk_en && wd_run && svc && wd_closed
    |=> !watchdog_fault_out_n)
    else $error("closed window service not punished");
  rst_leave_a: assert property ($changed(state_q) && $past(state_q) == st_reset
    |-> state_q == st_norm_req && $past(tmr_q) == 32'(RST_DUR - 1))
    else $error("reset mode left early or late");
  sleep_out_a: assert property (clk_en && state_q == st_sleep && !wake_ev
    |=> !rst_n && int_n && !main_reg_on)
    else $error("sleep outputs wrong");
  stop_wake_a: assert property (clk_en && state_q == st_stop && wake_ev && !vdd_low
    && !(wd_bad && !safe_mode) |=> state_q == st_norm_req && !int_n && rst_n)
    else $error("stop wake-up without interrupt");
  sleep_wake_a: assert property (clk_en && state_q == st_sleep && wake_ev
    |=> state_q == st_reset && main_reg_on && !rst_n)
    else $error("sleep wake-up without regulator");
  forced_excl_a: assert property (clk_en && low_power_wr && cfg_ok &&
    low_power_data.input_bias_from_switch && low_power_data.switch_auto_cycle
    |=> !forced_wake_en)
    else $error("forced wake enabled with cyclic sense");
  norm_req_out_a: assert property (state_q == st_norm_req
    |-> !tracking_regulator && !battery_high_side_switch && main_reg_on)
    else $error("normal request outputs wrong");

  stop_wake_c: cover property (state_q == st_stop ##1 state_q == st_norm_req ##1 !int_n);
  cyclic_wake_c: cover property (cyclic && sample_pt && |line_hit);
  safe_fault_c: cover property (safe_mode && wd_bad);
  sleep_wake_c: cover property (state_q == st_sleep ##1 state_q == st_reset);

endmodule // sbc_reset_watchdog_wakeup

`default_nettype wire
